// file: hdl/asrb_pkg.sv
package asrb_pkg;
   // Register byte offsets on the APB
   localparam logic [7:0] A_STAT = 8'h00;
   localparam logic [7:0] A_DATA = 8'h04;
   localparam logic [7:0] A_BAUD = 8'h08;
   localparam logic [7:0] A_CTL1 = 8'h0c;
   localparam logic [7:0] A_CTL2 = 8'h10;
   localparam logic [7:0] A_RFINE = 8'h14;
   localparam logic [7:0] A_TFINE = 8'h18;
   // Reset values
   localparam logic [7:0] STAT_RST = 8'hc0;
   localparam logic [7:0] CTL1_RST = 8'h00;
   localparam logic [7:0] CTL2_RST = 8'h00;
   localparam logic [7:0] BAUD_RST = 8'h00;
   localparam logic [7:0] FINE_RST = 8'h00;
   // Status bit positions
   localparam int B_TBE = 7;
   localparam int B_TC = 6;
   localparam int B_RXF = 5;
   localparam int B_IDLE = 4;
   localparam int B_OVR = 3;
   localparam int B_NF = 2;
   localparam int B_FE = 1;
   // Frame format control bits
   localparam int B_R9 = 7;
   localparam int B_T9 = 6;
   localparam int B_LEN = 4;
   localparam int B_WAKE = 3;
   // Enable control bits
   localparam int B_TIE = 7;
   localparam int B_TX_DONE_IRQ_EN = 6;
   localparam int B_RIE = 5;
   localparam int B_IDLE_IRQ_EN = 4;
   localparam int B_TE = 3;
   localparam int B_RE = 2;
   localparam int B_MUTE = 1;
   localparam int B_SBK = 0;
   // Baud fields and timing
   localparam int B_SCP = 6;
   localparam int B_TSEL = 3;
   localparam int B_RSEL = 0;
   localparam int OSR = 16;
   localparam logic [11:0] CONV_MUL = 12'h002;
   localparam logic [3:0] BITS8 = 4'ha;
   localparam logic [3:0] BITS9 = 4'hb;
   localparam logic [3:0] PH_S0 = 4'h7;
   localparam logic [3:0] PH_S1 = 4'h8;
   localparam logic [3:0] PH_DEC = 4'h9;
   localparam logic [3:0] PH_END = 4'hf;

   typedef struct packed {
      logic [8:0] data;
      logic nf;
      logic fe;
   } asrb_rxw_s;

   typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} asrb_tx_e;
   typedef enum logic [1:0] {RX_HUNT = 2'b01, RX_BITS = 2'b10} asrb_rx_e;

   // Cycles per oversample tick: fine value, else 2*PR*2^sel (32x overall)
   function automatic logic [11:0] asrb_per(logic [1:0] prescale_sel, logic [2:0] sel, logic [7:0] fine);
      logic [11:0] pf;
      pf = 12'h001;
      unique case (prescale_sel)
         2'b00: pf = 12'h001;
         2'b01: pf = 12'h003;
         2'b10: pf = 12'h004;
         2'b11: pf = 12'h00d;
      endcase
      if (fine != 8'h00)
         return {4'h0, fine};
      return 12'((CONV_MUL * pf) << sel);
   endfunction : asrb_per
endpackage : asrb_pkg

// file: hdl/asrb_top.sv
`timescale 1ns/1ns
module asrb_top (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   output logic serial_out_oe,
   output logic irq
);
   logic tbe_r, tc_r, rxf_r, idle_r, ovr_r, nf_r, fe_r, armed_r, seen_r;
   logic [7:0] ctl1_r, ctl2_r, baud_r, rfine_r, tfine_r, txh_r, rxh_r, rmux;
   logic hit, acc, wr, rd, rd_clr, wr_clr, tx_load, tc_set, done, idle_ev;
   logic [11:0] per [2];
   logic ten [2];
   logic tick [2];
   asrb_pkg::asrb_rxw_s rxw_r;
   asrb_pkg::asrb_tx_e tx_st_r;
   asrb_pkg::asrb_rx_e rx_st_r;

   wire len9 = ctl1_r[asrb_pkg::B_LEN];
   wire re = ctl2_r[asrb_pkg::B_RE];
   wire te = ctl2_r[asrb_pkg::B_TE];
   wire mute = ctl2_r[asrb_pkg::B_MUTE];
   wire break_send = ctl2_r[asrb_pkg::B_SBK];

   // APB slave: one wait state, so every answer comes from a flop
   assign acc = psel & penable & pready;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign rd_clr = rd & (paddr == asrb_pkg::A_DATA) & seen_r;
   assign wr_clr = wr & (paddr == asrb_pkg::A_DATA) & seen_r;

   always_comb begin
      hit = 1'b1;
      rmux = 8'h00;
      unique case (paddr)
         asrb_pkg::A_STAT: rmux = {tbe_r, tc_r, rxf_r, idle_r, ovr_r, nf_r, fe_r, 1'b0};
         asrb_pkg::A_DATA: rmux = rxh_r;
         asrb_pkg::A_BAUD: rmux = baud_r;
         asrb_pkg::A_CTL1: rmux = ctl1_r;
         asrb_pkg::A_CTL2: rmux = ctl2_r;
         asrb_pkg::A_RFINE: rmux = rfine_r;
         asrb_pkg::A_TFINE: rmux = tfine_r;
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         prdata <= (psel & penable & ~pready & ~pwrite) ? {24'h00_0000, rmux} : 32'h0000_0000;
         pslverr <= psel & penable & ~pready & ~hit;
      end
   end

   // Status access arms the clearing sequence; any data access ends it
   always_ff @(posedge sys_clk) begin
      if (rst)
         seen_r <= 1'b0;
      else if (acc && paddr == asrb_pkg::A_DATA)
         seen_r <= 1'b0;
      else if (acc && paddr == asrb_pkg::A_STAT)
         seen_r <= 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         baud_r <= asrb_pkg::BAUD_RST;
         rfine_r <= asrb_pkg::FINE_RST;
         tfine_r <= asrb_pkg::FINE_RST;
         txh_r <= 8'h00;
      end else if (wr) begin
         if (paddr == asrb_pkg::A_BAUD)
            baud_r <= pwdata[7:0];
         if (paddr == asrb_pkg::A_RFINE)
            rfine_r <= pwdata[7:0];
         if (paddr == asrb_pkg::A_TFINE)
            tfine_r <= pwdata[7:0];
         if (paddr == asrb_pkg::A_DATA)
            txh_r <= pwdata[7:0];
      end
   end

   // Baud tick generators, index 0 transmit, 1 receive
   assign per[0] = asrb_pkg::asrb_per(baud_r[asrb_pkg::B_SCP +: 2], baud_r[asrb_pkg::B_TSEL +: 3], tfine_r);
   assign per[1] = asrb_pkg::asrb_per(baud_r[asrb_pkg::B_SCP +: 2], baud_r[asrb_pkg::B_RSEL +: 3], rfine_r);
   assign ten[0] = te | (tx_st_r == asrb_pkg::TX_SHIFT);
   assign ten[1] = re;

   for (genvar g = 0; g < 2; g++) begin : g_tick
      logic [11:0] cnt_r;
      // Sixteen ticks per bit: 32*PR*div or 16*fine clocks per bit
      always_ff @(posedge sys_clk) begin
         if (rst || !ten[g]) begin
            cnt_r <= 12'h000;
            tick[g] <= 1'b0;
         end else if (cnt_r >= per[g] - 12'h001) begin
            cnt_r <= 12'h000;
            tick[g] <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 12'h001;
            tick[g] <= 1'b0;
         end
      end
   end

   // Transmitter
   logic [10:0] tsh_r;
   logic [3:0] tbits_r, tph_r;
   logic brk_pend_r, pre_pend_r, te_d_r, sbk_d_r;

   assign tx_load = (tx_st_r == asrb_pkg::TX_IDLE) & te & ~break_send & ~brk_pend_r & ~pre_pend_r & ~tbe_r;
   assign tc_set = (tx_st_r == asrb_pkg::TX_SHIFT) & tick[0] & (tph_r == asrb_pkg::PH_END) & (tbits_r == 4'h1);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_st_r <= asrb_pkg::TX_IDLE;
         tsh_r <= '1;
         tbits_r <= 4'h0;
         tph_r <= 4'h0;
         brk_pend_r <= 1'b0;
         pre_pend_r <= 1'b0;
         te_d_r <= 1'b0;
         sbk_d_r <= 1'b0;
      end else begin
         te_d_r <= te;
         sbk_d_r <= break_send;
         if (break_send && !sbk_d_r)
            brk_pend_r <= 1'b1;
         if (te && !te_d_r && tx_st_r == asrb_pkg::TX_SHIFT)
            pre_pend_r <= 1'b1;
         unique case (tx_st_r)
            asrb_pkg::TX_IDLE: begin
               tph_r <= 4'h0;
               tbits_r <= len9 ? asrb_pkg::BITS9 : asrb_pkg::BITS8;
               if (te && (break_send || brk_pend_r)) begin
                  tsh_r <= '0;
                  brk_pend_r <= 1'b0;
                  tx_st_r <= asrb_pkg::TX_SHIFT;
               end else if (te && pre_pend_r) begin
                  tsh_r <= '1;
                  pre_pend_r <= 1'b0;
                  tx_st_r <= asrb_pkg::TX_SHIFT;
               end else if (tx_load) begin
                  tsh_r <= {1'b1, len9 ? ctl1_r[asrb_pkg::B_T9] : 1'b1, txh_r, 1'b0};
                  tx_st_r <= asrb_pkg::TX_SHIFT;
               end
            end
            asrb_pkg::TX_SHIFT: begin
               if (tick[0]) begin
                  tph_r <= tph_r + 4'h1;
                  if (tph_r == asrb_pkg::PH_END) begin
                     tsh_r <= {1'b1, tsh_r[10:1]};
                     tbits_r <= tbits_r - 4'h1;
                     if (tbits_r == 4'h1)
                        tx_st_r <= asrb_pkg::TX_IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         serial_out_pin <= 1'b1;
         serial_out_oe <= 1'b0;
      end else begin
         serial_out_pin <= (tx_st_r == asrb_pkg::TX_SHIFT) ? tsh_r[0] : 1'b1;
         serial_out_oe <= te;
      end
   end

   // Transmit flags: the hardware set wins over the clearing write
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tbe_r <= asrb_pkg::STAT_RST[asrb_pkg::B_TBE];
         tc_r <= asrb_pkg::STAT_RST[asrb_pkg::B_TC];
      end else begin
         if (tx_load)
            tbe_r <= 1'b1;
         else if (wr_clr)
            tbe_r <= 1'b0;
         if (tc_set)
            tc_r <= 1'b1;
         else if (wr_clr)
            tc_r <= 1'b0;
      end
   end

   // Receiver: majority of three samples mid-bit, noise if they differ
   logic rs1_r, rs2_r, rs3_r, s0_r, s1_r, nacc_r;
   logic [3:0] rph_r, ridx_r;
   logic [7:0] icnt_r;
   wire rmaj = (s0_r & s1_r) | (s0_r & rs2_r) | (s1_r & rs2_r);
   wire rnz = ~((s0_r == s1_r) & (s1_r == rs2_r));
   wire [3:0] rlast = len9 ? asrb_pkg::BITS9 - 4'h1 : asrb_pkg::BITS8 - 4'h1;
   wire [7:0] ilim = len9 ? 8'(asrb_pkg::OSR * 11) : 8'(asrb_pkg::OSR * 10);
   wire rdec = tick[1] & (rph_r == asrb_pkg::PH_DEC) & (rx_st_r == asrb_pkg::RX_BITS);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rs1_r <= 1'b1;
         rs2_r <= 1'b1;
         rs3_r <= 1'b1;
      end else begin
         rs1_r <= serial_in_pin;
         rs2_r <= rs1_r;
         rs3_r <= rs2_r;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || !re) begin
         rx_st_r <= asrb_pkg::RX_HUNT;
         rph_r <= 4'h0;
         ridx_r <= 4'h0;
         s0_r <= 1'b1;
         s1_r <= 1'b1;
         nacc_r <= 1'b0;
         done <= 1'b0;
         rxw_r <= '0;
      end else begin
         done <= 1'b0;
         unique case (rx_st_r)
            asrb_pkg::RX_HUNT: begin
               if (rs3_r && !rs2_r) begin
                  rx_st_r <= asrb_pkg::RX_BITS;
                  rph_r <= 4'h0;
                  ridx_r <= 4'h0;
                  nacc_r <= 1'b0;
               end
            end
            asrb_pkg::RX_BITS: begin
               if (tick[1]) begin
                  rph_r <= rph_r + 4'h1;
                  if (rph_r == asrb_pkg::PH_S0)
                     s0_r <= rs2_r;
                  if (rph_r == asrb_pkg::PH_S1)
                     s1_r <= rs2_r;
               end
               if (rdec) begin
                  ridx_r <= ridx_r + 4'h1;
                  if (ridx_r == 4'h0) begin
                     if (rmaj)
                        rx_st_r <= asrb_pkg::RX_HUNT;
                  end else if (ridx_r < rlast) begin
                     rxw_r.data[ridx_r - 4'h1] <= rmaj;
                     nacc_r <= nacc_r | rnz;
                  end else begin
                     if (!len9)
                        rxw_r.data[8] <= 1'b0;
                     rxw_r.nf <= nacc_r | rnz;
                     rxw_r.fe <= ~rmaj;
                     done <= 1'b1;
                     rx_st_r <= asrb_pkg::RX_HUNT;
                  end
               end
            end
         endcase
      end
   end

   // Idle: a full frame of high line while hunting, reported once
   always_ff @(posedge sys_clk) begin
      if (rst || !re || !rs2_r || rx_st_r != asrb_pkg::RX_HUNT)
         icnt_r <= 8'h00;
      else if (tick[1] && icnt_r != ilim)
         icnt_r <= icnt_r + 8'h01;
   end
   assign idle_ev = re & rs2_r & tick[1] & (rx_st_r == asrb_pkg::RX_HUNT) & (icnt_r == ilim - 8'h01);

   wire wmsb = len9 ? rxw_r.data[8] : rxw_r.data[7];
   wire wake_addr = done & mute & ctl1_r[asrb_pkg::B_WAKE] & wmsb;
   wire wake_idle = idle_ev & mute & ~ctl1_r[asrb_pkg::B_WAKE];
   wire accept = done & (~mute | wake_addr);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctl1_r <= asrb_pkg::CTL1_RST;
         ctl2_r <= asrb_pkg::CTL2_RST;
         rxh_r <= 8'h00;
      end else begin
         if (wake_addr || wake_idle)
            ctl2_r[asrb_pkg::B_MUTE] <= 1'b0;
         if (wr && paddr == asrb_pkg::A_CTL2)
            ctl2_r <= pwdata[7:0];
         if (wr && paddr == asrb_pkg::A_CTL1) begin
            ctl1_r[asrb_pkg::B_T9] <= pwdata[asrb_pkg::B_T9];
            ctl1_r[asrb_pkg::B_LEN] <= pwdata[asrb_pkg::B_LEN];
            ctl1_r[asrb_pkg::B_WAKE] <= pwdata[asrb_pkg::B_WAKE];
         end
         if (accept && !rxf_r) begin
            rxh_r <= rxw_r.data[7:0];
            ctl1_r[asrb_pkg::B_R9] <= rxw_r.data[8];
         end
      end
   end

   // Receive flags; a new event wins over the clearing read
   always_ff @(posedge sys_clk) begin
      if (rst || !re) begin
         rxf_r <= 1'b0;
         idle_r <= 1'b0;
         ovr_r <= 1'b0;
         nf_r <= 1'b0;
         fe_r <= 1'b0;
         armed_r <= 1'b1;
      end else begin
         if (accept && !rxf_r)
            rxf_r <= 1'b1;
         else if (rd_clr)
            rxf_r <= 1'b0;
         if (accept && rxf_r)
            ovr_r <= 1'b1;
         else if (rd_clr)
            ovr_r <= 1'b0;
         if (accept && !rxf_r && rxw_r.nf)
            nf_r <= 1'b1;
         else if (rd_clr)
            nf_r <= 1'b0;
         if (accept && !rxf_r && rxw_r.fe)
            fe_r <= 1'b1;
         else if (rd_clr)
            fe_r <= 1'b0;
         if (idle_ev && !mute && armed_r)
            idle_r <= 1'b1;
         else if (rd_clr)
            idle_r <= 1'b0;
         if (accept && !rxf_r)
            armed_r <= 1'b1;
         else if (idle_ev && !mute)
            armed_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= (ctl2_r[asrb_pkg::B_TIE] & tbe_r) | (ctl2_r[asrb_pkg::B_TX_DONE_IRQ_EN] & tc_r)
              | (ctl2_r[asrb_pkg::B_RIE] & (rxf_r | ovr_r)) | (ctl2_r[asrb_pkg::B_IDLE_IRQ_EN] & idle_r);
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence load_seq;
      tx_load ##1 (tx_st_r == asrb_pkg::TX_SHIFT);
   endsequence

   tbe_load_a: assert property (load_seq |-> tbe_r) else $error("empty flag not set on load");
   tc_end_a: assert property (tc_set |=> tc_r && tx_st_r == asrb_pkg::TX_IDLE) else $error("done flag missing");
   rx_off_a: assert property (!re |=> !rxf_r && !ovr_r && !idle_r && !nf_r && !fe_r) else $error("flags survive disable");
   ovr_keep_a: assert property (accept && rxf_r |=> ovr_r && rxh_r == $past(rxh_r) && !($rose(fe_r)))
      else $error("overrun handling wrong");
   irq_lvl_a: assert property (re && rxf_r && ctl2_r[asrb_pkg::B_RIE] |=> irq) else $error("receive irq missing");
   rd_clr_a: assert property (rd_clr && !accept && re |=> !rxf_r) else $error("read sequence failed to clear");
   wake_idle_a: assert property (wake_idle |=> !mute && !$rose(idle_r)) else $error("idle wake wrong");
   wake_addr_a: assert property (wake_addr && !rxf_r && re |=> !mute ##0 rxf_r) else $error("address wake wrong");
   pin_own_a: assert property (te |=> serial_out_oe) else $error("pin not handed over");
   brk_low_a: assert property ($rose(tx_st_r == asrb_pkg::TX_SHIFT) && tsh_r == '0 |=> !serial_out_pin)
      else $error("break not low");
endmodule : asrb_top

// file: sim/asrb_line_far.sv
`timescale 1ns/1ns
module asrb_line_far (
   input wire logic sys_clk,
   input wire logic serial_out_pin,
   input wire logic serial_out_oe,
   input wire logic nine,
   input wire logic [15:0] bit_cyc,
   output logic serial_in_pin,
   output logic [9:0] rx_word,
   output logic rx_stb
);
   logic line_w;
   // Port control leaves the pin to its pull-up
   assign line_w = serial_out_oe ? serial_out_pin : 1'b1;
   initial begin
      serial_in_pin = 1'b1;
      rx_word = 10'h000;
      rx_stb = 1'b0;
   end
   task automatic send(input logic [8:0] w, input logic bad_stop);
      logic [10:0] f;
      int n;
      n = nine ? 11 : 10;
      f = nine ? {~bad_stop, w, 1'b0} : {1'b1, ~bad_stop, w[7:0], 1'b0};
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         serial_in_pin <= f[i];
         repeat (bit_cyc - 1) @(posedge sys_clk);
      end
      @(posedge sys_clk);
      serial_in_pin <= 1'b1;
   endtask : send
   // Samples mid-bit; stop bit reported in bit 9
   always begin : rx_proc
      logic [8:0] w;
      @(posedge sys_clk);
      if (line_w === 1'b0) begin
         w = 9'h000;
         repeat (bit_cyc / 2) @(posedge sys_clk);
         for (int i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (bit_cyc) @(posedge sys_clk);
            w[i] = line_w;
         end
         repeat (bit_cyc) @(posedge sys_clk);
         rx_word <= {line_w, w};
         rx_stb <= 1'b1;
         @(posedge sys_clk);
         rx_stb <= 1'b0;
         // A break holds the line low past the stop slot
         wait (line_w === 1'b1);
      end
   end
endmodule : asrb_line_far

// file: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, serial_in_pin, serial_out_pin, serial_out_oe, irq, rx_stb;
   logic [9:0] rx_word;
   logic nine = 1'b0;
   logic [15:0] bitc = 16'h0010;
   logic [31:0] seed = 32'h00000055;
   int bad_count = 0;
   int checked = 0;
   int cyc = 0;
   logic [32:0] exp_rd[$];
   logic [32:0] msk_rd[$];
   logic [9:0] exp_ln[$];
   int pr_tab[4] = '{1, 3, 4, 13};
   logic [7:0] bv[5] = '{8'h00, 8'h48, 8'h90, 8'hc0, 8'hc0};
   logic [7:0] fv[5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h05};

   always #5 sys_clk = ~sys_clk;

   asrb_top dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
      .irq(irq));
   asrb_line_far line (.sys_clk(sys_clk), .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
      .nine(nine), .bit_cyc(bitc), .serial_in_pin(serial_in_pin), .rx_word(rx_word), .rx_stb(rx_stb));

   function automatic logic [7:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : xs
   task automatic miss(input string m);
      bad_count++;
      $display("FAIL %0t %s", $time, m);
   endtask : miss
   task automatic test_done();
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done
   task automatic tend(input string s);
      $display("%0t test %s done", $time, s);
   endtask : tend
   task automatic cmp_rd(input logic [32:0] g, input logic [32:0] e, input logic [32:0] m);
      checked++;
      if (((g ^ e) & m) !== 33'h0)
         miss("read data");
   endtask : cmp_rd
   task automatic cmp_ln(input logic [9:0] g, input logic [9:0] e);
      checked++;
      if (g !== e)
         miss("line word");
   endtask : cmp_ln
   task automatic cmp_pin(input logic g, input logic e);
      checked++;
      if (g !== e)
         miss("pin level");
   endtask : cmp_pin
   task automatic cmp_n(input int g, input int e);
      checked++;
      if (g != e)
         miss("bit length");
   endtask : cmp_n
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (pready !== 1'b1)
         miss("no ready");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input logic er = 1'b0);
      exp_rd.push_back({er, 24'h000000, e});
      msk_rd.push_back({1'b1, 24'hffffff, m});
      xfer(1'b0, a, 8'h00);
   endtask : rd
   // Status access first, else the data write leaves TBE set and nothing is sent
   task automatic tx(input logic [8:0] w);
      rd(asrb_pkg::A_STAT, 8'h00, 8'h00);
      exp_ln.push_back({1'b1, nine ? w : {1'b0, w[7:0]}});
      wr(asrb_pkg::A_DATA, w[7:0]);
   endtask : tx
   task automatic wait_ln();
      int n;
      n = 0;
      while (exp_ln.size() != 0 && n < 50000) begin
         @(posedge sys_clk);
         n++;
      end
      repeat (bitc) @(posedge sys_clk);
   endtask : wait_ln
   task automatic meas(output int n);
      int t;
      n = 0;
      t = 0;
      while (serial_out_pin !== 1'b0 && t < 5000) begin
         @(posedge sys_clk);
         t++;
      end
      // Start bit phase depends on the free tick; skip it and bit 0
      while (serial_out_pin === 1'b0 && t < 10000) begin
         @(posedge sys_clk);
         t++;
      end
      while (serial_out_pin !== 1'b0 && t < 15000) begin
         @(posedge sys_clk);
         t++;
      end
      while (serial_out_pin === 1'b0 && n < 10000) begin
         @(posedge sys_clk);
         n++;
      end
   endtask : meas

   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (exp_rd.size() == 0)
            miss("unexpected read");
         else
            cmp_rd({pslverr, prdata}, exp_rd.pop_front(), msk_rd.pop_front());
      end
      if (rx_stb === 1'b1) begin
         if (exp_ln.size() == 0)
            miss("unexpected word");
         else
            cmp_ln(rx_word, exp_ln.pop_front());
      end
      if (cyc == 40000) begin
         miss("timeout");
         test_done();
      end
   end

   initial begin
      int n;
      int e;
      logic [7:0] v;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      rd(asrb_pkg::A_STAT, asrb_pkg::STAT_RST, 8'hff);
      for (int i = 2; i < 7; i++)
         rd(8'(i * 4), 8'h00, 8'hff);
      rd(8'h1c, 8'h00, 8'hff, 1'b1);
      wr(asrb_pkg::A_STAT, 8'h3f);
      rd(asrb_pkg::A_STAT, 8'hc0, 8'hff);
      cmp_pin(irq, 1'b0);
      cmp_pin(serial_out_oe, 1'b0);
      tend("registers");
      wr(asrb_pkg::A_TFINE, 8'h01);
      wr(asrb_pkg::A_RFINE, 8'h01);
      wr(asrb_pkg::A_CTL2, 8'h08);
      repeat (3) @(posedge sys_clk);
      cmp_pin(serial_out_oe, 1'b1);
      tx({1'b0, xs()});
      rd(asrb_pkg::A_STAT, 8'h80, 8'hc0);
      wait_ln();
      rd(asrb_pkg::A_STAT, 8'hc0, 8'hc0);
      wr(asrb_pkg::A_CTL2, 8'h88);
      repeat (3) @(posedge sys_clk);
      cmp_pin(irq, 1'b1);
      wr(asrb_pkg::A_CTL1, 8'h50);
      nine = 1'b1;
      tx({1'b1, xs()});
      wait_ln();
      wr(asrb_pkg::A_CTL2, 8'h09);
      wr(asrb_pkg::A_CTL2, 8'h08);
      exp_ln.push_back(10'h000);
      wait_ln();
      wr(asrb_pkg::A_CTL1, 8'h00);
      nine = 1'b0;
      wr(asrb_pkg::A_CTL2, 8'h00);
      repeat (3) @(posedge sys_clk);
      cmp_pin(serial_out_oe, 1'b0);
      cmp_pin(irq, 1'b0);
      tend("transmit");
      wr(asrb_pkg::A_CTL2, 8'h08);
      // Word 0x001: bits 1 to 7 form one low run of seven bit times
      for (int i = 0; i < 5; i++) begin
         wr(asrb_pkg::A_TFINE, fv[i]);
         wr(asrb_pkg::A_BAUD, bv[i]);
         e = fv[i] != 8'h00 ? 16 * fv[i] : 32 * pr_tab[bv[i][7:6]] * (1 << bv[i][5:3]);
         bitc = 16'(e);
         tx(9'h001);
         meas(n);
         cmp_n(n, 7 * e);
         wait_ln();
      end
      wr(asrb_pkg::A_TFINE, 8'h01);
      wr(asrb_pkg::A_BAUD, 8'h00);
      bitc = 16'h0010;
      tend("baud");
      wr(asrb_pkg::A_CTL2, 8'h24);
      v = xs();
      line.send({1'b0, v}, 1'b0);
      repeat (4) @(posedge sys_clk);
      cmp_pin(irq, 1'b1);
      rd(asrb_pkg::A_STAT, 8'h20, 8'h2e);
      rd(asrb_pkg::A_DATA, v, 8'hff);
      rd(asrb_pkg::A_STAT, 8'h00, 8'h20);
      cmp_pin(irq, 1'b0);
      repeat (192) @(posedge sys_clk);
      rd(asrb_pkg::A_STAT, 8'h10, 8'h10);
      wr(asrb_pkg::A_CTL2, 8'h34);
      repeat (3) @(posedge sys_clk);
      cmp_pin(irq, 1'b1);
      rd(asrb_pkg::A_DATA, v, 8'hff);
      wr(asrb_pkg::A_CTL2, 8'h24);
      repeat (192) @(posedge sys_clk);
      rd(asrb_pkg::A_STAT, 8'h00, 8'h10);
      wr(asrb_pkg::A_CTL1, 8'h10);
      nine = 1'b1;
      line.send({1'b1, v}, 1'b0);
      repeat (4) @(posedge sys_clk);
      rd(asrb_pkg::A_STAT, 8'h20, 8'h20);
      rd(asrb_pkg::A_CTL1, 8'h80, 8'h80);
      rd(asrb_pkg::A_DATA, v, 8'hff);
      wr(asrb_pkg::A_CTL1, 8'h00);
      nine = 1'b0;
      tend("receive");
      v = xs();
      line.send({1'b0, v}, 1'b0);
      line.send({1'b0, xs()}, 1'b0);
      repeat (4) @(posedge sys_clk);
      rd(asrb_pkg::A_STAT, 8'h28, 8'h2a);
      rd(asrb_pkg::A_DATA, v, 8'hff);
      v = xs();
      line.send({1'b0, v}, 1'b0);
      line.send({1'b0, xs()}, 1'b1);
      repeat (4) @(posedge sys_clk);
      rd(asrb_pkg::A_STAT, 8'h28, 8'h2a);
      rd(asrb_pkg::A_DATA, v, 8'hff);
      line.send({1'b0, xs()}, 1'b1);
      repeat (4) @(posedge sys_clk);
      rd(asrb_pkg::A_STAT, 8'h22, 8'h2a);
      wr(asrb_pkg::A_CTL2, 8'h20);
      rd(asrb_pkg::A_STAT, 8'h00, 8'h3e);
      tend("errors");
      wr(asrb_pkg::A_CTL1, 8'h08);
      wr(asrb_pkg::A_CTL2, 8'h26);
      line.send(9'h012, 1'b0);
      repeat (4) @(posedge sys_clk);
      rd(asrb_pkg::A_STAT, 8'h00, 8'h20);
      line.send(9'h092, 1'b0);
      repeat (4) @(posedge sys_clk);
      rd(asrb_pkg::A_STAT, 8'h20, 8'h20);
      rd(asrb_pkg::A_CTL2, 8'h24, 8'hff);
      rd(asrb_pkg::A_DATA, 8'h92, 8'hff);
      wr(asrb_pkg::A_CTL1, 8'h00);
      wr(asrb_pkg::A_CTL2, 8'h26);
      repeat (192) @(posedge sys_clk);
      rd(asrb_pkg::A_CTL2, 8'h24, 8'h02);
      rd(asrb_pkg::A_STAT, 8'h00, 8'h10);
      tend("mute");
      test_done();
   end
endmodule : tb_top
